// File: hw/cborec_top.sv
`timescale 1ns/1ps
`default_nettype none
// Bus-off recovery control: decides when a bus-off node may go error active.
// The block sees the sampled bus bits of the wider controller as strobes.
// Each strobe carries one bit value, recessive or dominant.
// A run of recessive bits is counted in a small counter module.
// Each completed run counts as one idle sequence on the bus.
// Once enough sequences are seen, the count is marked as done.
// In automatic mode a done count ends bus-off at once.
// In request mode the hold bit must also be clear.
// The hold bit is written by software through set and clear pulses.
// A clear that comes before the count is done is kept in the hold bit.
// A count that is done first waits in its own state for that clear.
// Sleep only stops the strobes; the counts already gathered are kept.
// A fresh entry into bus-off always starts the count from zero.
// Every output leaves a flip-flop, so all of them lag their cause.
module cborec_top #(
  parameter int unsigned RUN_LEN    = cborec_pkg::RECESSIVE_RUN_LEN,
  parameter int unsigned SEQ_TARGET = cborec_pkg::SEQUENCE_TARGET
) (
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic recovery_on_request_select_in,
  input  wire logic bus_off_hold_set_in,
  input  wire logic bus_off_hold_clear_in,
  input  wire logic bus_off_enter_in,
  input  wire logic sleep_in,
  input  wire logic bit_strobe_in,
  input  wire logic bit_recessive_in,
  output logic      recovery_on_request_select_out,
  output logic      bus_off_hold_out,
  output logic      bus_off_out,
  output logic      count_done_out,
  output logic      recover_out
);

  // Width of the sequence counter; it must reach the target itself.
  // Any values above the target are never used, as the count saturates.
  localparam int unsigned SW = $clog2(SEQ_TARGET + 1);

  initial begin
    if (SEQ_TARGET < 1) begin
      $error("SEQ_TARGET must be at least one.");
    end
  end

  cborec_pkg::cborec_state_t state_ff;
  cborec_pkg::cborec_state_t nxt_state;
  logic [SW-1:0] seq_cnt_ff;
  logic [SW-1:0] nxt_seq_cnt;
  logic          mode_ff;
  logic          hold_ff;
  logic          nxt_hold;
  logic          done_ff;
  logic          nxt_done;
  logic          recover_ff;
  logic          nxt_recover;
  logic          run_done;
  logic          counting;
  logic          run_clear;
  logic          seq_last;
  logic          hold_released;
  logic          leave_now;

  // Sequences are counted only while bus-off; sleep does not reset them.
  // Runs are cleared outside the counting state, so a stale partial run
  // from an earlier bus-off period can never shorten a new recovery.
  // A run that ends in the very cycle of a new entry is dropped as well.
  assign counting  = (state_ff == cborec_pkg::CBOREC_BUS_OFF);
  assign run_clear = bus_off_enter_in || !counting;

  cborec_run_counter #(
    .RUN_LEN          (RUN_LEN)
  ) u_run (
    .clk_sys_in       (clk_sys_in),
    .rst_n_in         (rst_n_in),
    .clear_in         (run_clear),
    .bit_strobe_in    (bit_strobe_in && !sleep_in),
    .bit_recessive_in (bit_recessive_in),
    .run_done_out     (run_done)
  );

  // Sequence count saturates at the target; fresh on each bus-off entry.
  // The done flag is the registered form of the saturated count.
  // It stays high after recovery until the next entry clears it,
  // so software can still see that the last recovery was complete.
  // Entry has priority over a run that completes in the same cycle.
  assign seq_last    = run_done && counting &&
                       (seq_cnt_ff == SW'(SEQ_TARGET - 1));
  assign nxt_seq_cnt = bus_off_enter_in ? '0 :
                       (run_done && counting && !done_ff) ?
                       seq_cnt_ff + SW'(1) : seq_cnt_ff;
  assign nxt_done    = bus_off_enter_in ? 1'b0 :
                       (done_ff || seq_last);

  // Hold: a clear is remembered even before the count is done.
  // Clear wins over set in one cycle, as both come from software.
  // The hold bit has no hardware source, so no set-versus-clear race
  // with a hardware event can occur here.
  assign nxt_hold      = bus_off_hold_clear_in ? 1'b0 :
                         (bus_off_hold_set_in ? 1'b1 : hold_ff);
  assign hold_released = !hold_ff;

  // Automatic mode needs the count only; request mode needs both.
  // The registered hold value is used, so recovery follows a clear one
  // cycle later; a set in the same cycle still blocks the exit.
  // The mode is applied from its register, one cycle after the input.
  assign leave_now = nxt_done &&
                     (!mode_ff || (hold_released && !bus_off_hold_set_in));

  // Recovery state sequencing.
  // Active: normal operation, waiting for an entry pulse.
  // Bus-off: counting sequences toward the target.
  // Wait: count done in request mode, waiting for the hold clear.
  // An entry pulse in any state restarts the bus-off period.
  // The recover pulse is raised only on the step back to active.
  always_comb begin
    nxt_state   = state_ff;
    nxt_recover = 1'b0;
    case (state_ff)
      cborec_pkg::CBOREC_ACTIVE: begin
        if (bus_off_enter_in) begin
          nxt_state = cborec_pkg::CBOREC_BUS_OFF;
        end
      end
      cborec_pkg::CBOREC_BUS_OFF: begin
        if (bus_off_enter_in) begin
          nxt_state = cborec_pkg::CBOREC_BUS_OFF;
        end else if (leave_now) begin
          nxt_state   = cborec_pkg::CBOREC_ACTIVE;
          nxt_recover = 1'b1;
        end else if (nxt_done) begin
          nxt_state = cborec_pkg::CBOREC_WAIT;
        end
      end
      cborec_pkg::CBOREC_WAIT: begin
        if (bus_off_enter_in) begin
          nxt_state = cborec_pkg::CBOREC_BUS_OFF;
        end else if (leave_now) begin
          nxt_state   = cborec_pkg::CBOREC_ACTIVE;
          nxt_recover = 1'b1;
        end
      end
      default: begin
        nxt_state = cborec_pkg::CBOREC_ACTIVE;
      end
    endcase
  end

  // Mode and hold registers; automatic recovery after reset.
  // The mode is a plain level from software and is copied each cycle.
  // A change of mode during bus-off takes effect on the next cycle.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      mode_ff <= cborec_pkg::MODE_RESET;
      hold_ff <= cborec_pkg::HOLD_RESET;
    end else begin
      mode_ff <= recovery_on_request_select_in;
      hold_ff <= nxt_hold;
    end
  end

  // State, counter and pulse registers.
  // All of them return to the idle, error-active condition on reset.
  // The recover register holds a one-cycle pulse, never a level.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_ff   <= cborec_pkg::CBOREC_ACTIVE;
      seq_cnt_ff <= '0;
      done_ff    <= 1'b0;
      recover_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      seq_cnt_ff <= nxt_seq_cnt;
      done_ff    <= nxt_done;
      recover_ff <= nxt_recover;
    end
  end

  // Outputs straight from flip-flops.
  // Each output is fed from the next-state value of its internal twin,
  // so it matches that twin in the same cycle without extra delay.
  // Bus-off stays high in the wait state, as the node is not yet active.
  // The mode output is a copy of the input, one cycle late.
  // The hold output shows the hold bit as software last wrote it.
  // The done output shows whether this bus-off period is fully counted.
  // The recover output pulses once for each return to error active.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      recovery_on_request_select_out <= cborec_pkg::MODE_RESET;
      bus_off_hold_out               <= cborec_pkg::HOLD_RESET;
      bus_off_out                    <= 1'b0;
      count_done_out                 <= 1'b0;
      recover_out                    <= 1'b0;
    end else begin
      recovery_on_request_select_out <= recovery_on_request_select_in;
      bus_off_hold_out               <= nxt_hold;
      bus_off_out <= (nxt_state != cborec_pkg::CBOREC_ACTIVE);
      count_done_out                 <= nxt_done;
      recover_out                    <= nxt_recover;
    end
  end

endmodule : cborec_top
`default_nettype wire

// File: hw/cborec_pkg.sv
package cborec_pkg;

  // Recessive bits that make up one idle sequence.
  localparam int unsigned RECESSIVE_RUN_LEN = 11;
  // Idle sequences needed before bus-off may end.
  localparam int unsigned SEQUENCE_TARGET   = 128;
  // Reset value of the mode bit: automatic recovery.
  localparam logic        MODE_RESET        = 1'b0;
  // Reset value of the hold bit.
  localparam logic        HOLD_RESET        = 1'b0;

  // Recovery controller states.
  typedef enum logic [1:0] {
    CBOREC_ACTIVE  = 2'b00,
    CBOREC_BUS_OFF = 2'b01,
    CBOREC_WAIT    = 2'b10
  } cborec_state_t;

endpackage : cborec_pkg

// File: hw/cborec_run_counter.sv
`timescale 1ns/1ps
`default_nettype none
// Counts recessive bits and flags each completed run of RUN_LEN bits.
module cborec_run_counter #(
  parameter int unsigned RUN_LEN = cborec_pkg::RECESSIVE_RUN_LEN
) (
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic clear_in,
  input  wire logic bit_strobe_in,
  input  wire logic bit_recessive_in,
  output logic      run_done_out
);

  localparam int unsigned CW = $clog2(RUN_LEN + 1);

  initial begin
    if (RUN_LEN < 1) begin
      $error("RUN_LEN must be at least one.");
    end
  end

  logic [CW-1:0] run_cnt_ff;
  logic [CW-1:0] nxt_run_cnt;
  logic          run_hit;
  logic          nxt_run_done;

  // A dominant bit restarts the run; a full run restarts at zero.
  assign run_hit      = bit_strobe_in && bit_recessive_in &&
                        (run_cnt_ff == CW'(RUN_LEN - 1));
  assign nxt_run_cnt  = (clear_in || (bit_strobe_in && !bit_recessive_in)
                        || run_hit) ? '0 :
                        (bit_strobe_in ? run_cnt_ff + CW'(1) : run_cnt_ff);
  assign nxt_run_done = run_hit && !clear_in;

  // Run length register and its one-cycle completion pulse.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      run_cnt_ff   <= '0;
      run_done_out <= 1'b0;
    end else begin
      run_cnt_ff   <= nxt_run_cnt;
      run_done_out <= nxt_run_done;
    end
  end

endmodule : cborec_run_counter
`default_nettype wire

// File: tb/cborec_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the recovery block ports for mode, hold and recovery timing.
module cborec_properties (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic recovery_on_request_select_in,
  input wire logic bus_off_hold_set_in,
  input wire logic bus_off_hold_clear_in,
  input wire logic bus_off_enter_in,
  input wire logic sleep_in,
  input wire logic bit_strobe_in,
  input wire logic bit_recessive_in,
  input wire logic recovery_on_request_select_out,
  input wire logic bus_off_hold_out,
  input wire logic bus_off_out,
  input wire logic count_done_out,
  input wire logic recover_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // Three sleeping cycles in a row.
  sequence s_asleep;
    sleep_in [*3];
  endsequence
  // Each assertion ties an output to its cause.
  AST_MODE_COPY: assert property ($past(rst_n_in) |->
    recovery_on_request_select_out == $past(recovery_on_request_select_in))
    else $error("mode copy wrong");
  AST_RESET_AUTO: assert property (disable iff (1'h0) !rst_n_in |=>
    !recovery_on_request_select_out && !bus_off_out) else $error("reset");
  AST_AUTO_EXIT: assert property ($rose(count_done_out) &&
    !recovery_on_request_select_out |-> recover_out && !bus_off_out)
    else $error("auto recovery late");
  AST_PULSE: assert property (recover_out |=>
    !recover_out && (!bus_off_out || bus_off_enter_in))
    else $error("recover pulse too long");
  AST_NEED_BOTH: assert property (recover_out |-> count_done_out &&
    !(recovery_on_request_select_out && bus_off_hold_out))
    else $error("early recovery");
  AST_WAIT_CLEAR: assert property (count_done_out && bus_off_out &&
    bus_off_hold_out && recovery_on_request_select_out &&
    !bus_off_hold_clear_in && !bus_off_enter_in |=> bus_off_out)
    else $error("left bus-off while held");
  AST_SLEEP_HOLD: assert property (s_asleep |->
    !$rose(count_done_out)) else $error("counted while asleep");
  AST_ENTRY_CLEAR: assert property (bus_off_enter_in |=>
    bus_off_out && !count_done_out) else $error("entry not clean");
endmodule : cborec_properties
`default_nettype wire

// File: tb/cborec_can_nodes.sv
`timescale 1ns/1ps
`default_nettype none
// Other nodes on the bus: one sampled bit every two cycles when enabled.
module cborec_can_nodes (
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic enable_in,
  input  wire logic dominant_in,
  output logic      bit_strobe_out,
  output logic      bit_recessive_out
);
  // Between bits the level shows the inverse of the last bit.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      bit_strobe_out    <= 1'h0;
      bit_recessive_out <= 1'h1;
    end else begin
      bit_strobe_out    <= enable_in && !bit_strobe_out;
      bit_recessive_out <= (enable_in && !bit_strobe_out) ? !dominant_in
                                                          : !bit_recessive_out;
    end
  end
endmodule : cborec_can_nodes
`default_nettype wire

// File: tb/cborec_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Drives the recovery block and compares it with a reference model.
module cborec_top_tb;
  localparam int RL = 3;
  localparam int ST = 4;
  logic clk_sys_in, rst_n_in, recovery_on_request_select_in, sleep_in;
  logic bus_off_hold_set_in, bus_off_hold_clear_in, bus_off_enter_in;
  logic bit_strobe_in, bit_recessive_in, recovery_on_request_select_out;
  logic bus_off_hold_out, bus_off_out, count_done_out, recover_out;
  int   run, seq, errors, tests_run, seed = 60999;
  bit   bo, hold, md, rp, rec, en, dom;
  cborec_top #(.RUN_LEN(RL), .SEQ_TARGET(ST)) i_cborec_top (.clk_sys_in,
    .rst_n_in, .recovery_on_request_select_in, .bus_off_hold_set_in,
    .bus_off_hold_clear_in, .bus_off_enter_in, .sleep_in, .bit_strobe_in,
    .bit_recessive_in, .recovery_on_request_select_out, .bus_off_hold_out,
    .bus_off_out, .count_done_out, .recover_out);
  cborec_can_nodes i_cborec_can_nodes (.clk_sys_in, .rst_n_in,
    .enable_in(en), .dominant_in(dom), .bit_strobe_out(bit_strobe_in),
    .bit_recessive_out(bit_recessive_in));
  // Reference model, sampling inputs at the same edges as the design.
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      {bo, hold, md, rp, rec} = '0;
      run = 0;
      seq = 0;
    end else begin
      if (rp && bo && seq < ST) seq++;
      rp = 0;
      if (bo && bit_strobe_in && !sleep_in) begin
        run = bit_recessive_in ? run + 1 : 0;
        if (run == RL) begin
          rp = 1;
          run = 0;
        end
      end
      rec = bo && seq == ST && !(md && (hold || bus_off_hold_set_in));
      hold = bus_off_hold_clear_in ? 1'h0 : (bus_off_hold_set_in | hold);
      if (rec) bo = 0;
      if (bus_off_enter_in) begin
        {bo, rp, rec} = 3'h4;
        run = 0;
        seq = 0;
      end
      md = recovery_on_request_select_in;
    end
  end
  // Compares the results once the outputs have settled; the done flag only while bus-off or on a recovery.
  always @(negedge clk_sys_in) if (rst_n_in) begin
    check(recover_out, rec);
    check(bus_off_out, bo);
    check(bus_off_hold_out, hold);
    check(recovery_on_request_select_out, md);
    if (bo || rec) check(count_done_out, seq == ST);
  end
  task automatic check(input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %b want %b", $time, seen, exp);
    end
  endtask : check
  // Enters bus-off, then clears hold, sleeps and re-enters at given cycles.
  task automatic scen(input logic m, input int clr, slp, ent);
    for (int c = 0; c < 90; c++) begin
      @(posedge clk_sys_in);
      recovery_on_request_select_in <= m;
      bus_off_enter_in <= (c == 2) || (c == ent);
      bus_off_hold_set_in <= m && (c == 0);
      bus_off_hold_clear_in <= (c == clr);
      sleep_in <= (c >= slp) && (c < slp + 12);
      en <= c > 3;
      dom <= ($random(seed) % 8) == 0;
    end
    $display("test done at %0t", $time);
  endtask : scen
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // Free-running clock.
  initial begin
    clk_sys_in = 1'h0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // Reset, then auto, request count-first, clear-first, sleep, re-entry.
  initial begin
    {rst_n_in, recovery_on_request_select_in, bus_off_hold_set_in} = '0;
    {bus_off_hold_clear_in, bus_off_enter_in, sleep_in} = '0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'h1;
    scen(1'h0, 1, 999, 999);
    scen(1'h1, 70, 999, 999);
    scen(1'h1, 10, 999, 999);
    scen(1'h0, 1, 15, 999);
    scen(1'h0, 1, 999, 20);
    finish_test();
  end
  // Watchdog against a hang.
  initial begin
    #20000;
    errors++;
    finish_test();
  end
endmodule : cborec_top_tb
bind cborec_top cborec_properties i_cborec_properties (.clk_sys_in,
  .rst_n_in, .recovery_on_request_select_in, .bus_off_hold_set_in,
  .bus_off_hold_clear_in, .bus_off_enter_in, .sleep_in, .bit_strobe_in,
  .bit_recessive_in, .recovery_on_request_select_out, .bus_off_hold_out,
  .bus_off_out, .count_done_out, .recover_out);
`default_nettype wire
